// File: lcd_segment_driver.sv
// Segment LCD controller/driver: registers, display memory, clock divider, waveform levels.
// Assumes one clock, synchronous active-high reset, processor accesses synchronous to it.
`include "lcd_segment_driver_consts.svh"

module lcd_segment_driver
    import lcd_segment_driver_pkg::*;
#(
    parameter int NUM_SEG = 40,
    parameter int NUM_COM = 4
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_i,
    input  wire logic [15:0]             cpu_addr_i,
    input  wire logic                    cpu_wr_i,
    input  wire logic [7:0]              cpu_wdata_i,
    input  wire logic                    cpu_bit_wr_i,
    input  wire logic [2:0]              cpu_bit_sel_i,
    input  wire logic                    cpu_bit_val_i,
    input  wire logic                    cpu_rd_i,
    output logic      [7:0]              cpu_rdata_o,
    input  wire logic [2:0]              port_byte_sel_i,
    input  wire logic [15:0]             port_bit_sel_i,
    output logic      [NUM_SEG-1:0][1:0] seg_level_o,
    output logic      [NUM_SEG-1:0]      seg_drive_o,
    output logic      [NUM_COM-1:0][1:0] com_level_o,
    output logic      [NUM_COM-1:0]      com_drive_o,
    output logic                         drive_power_o,
    output logic                         panel_scan_clock_o
);

    logic [7:0]  mode_ff,  nxt_mode;
    logic [7:0]  ctrl_ff,  nxt_ctrl;
    logic [7:0]  rdata_ff, nxt_rdata;
    logic [3:0]  dmem_ff [NUM_SEG];
    logic [16:0] div_ff,   nxt_div;
    logic [1:0]  slot_ff,  nxt_slot;
    logic        pol_ff,   nxt_pol;
    logic        power_ff, nxt_power;
    logic [16:0] div_mask;
    logic        tick;
    logic [2:0]  nslots;
    logic        bias3;
    logic        static_mode;
    logic        disp_en;
    logic        last_slot;
    logic        dmem_hit;
    logic [15:0] dmem_off;
    logic [5:0]  dmem_idx;
    duty_e       duty;

    assign disp_en  = mode_ff[`DISPLAY_ENABLE_POS];
    assign dmem_hit = (cpu_addr_i >= `ADDR_DMEM_FIRST) && (cpu_addr_i <= `ADDR_DMEM_LAST);
    assign dmem_off = `ADDR_DMEM_LAST - cpu_addr_i;
    assign dmem_idx = dmem_off[5:0];

    // Register group: byte and bit writes, reads answered one cycle later
    always_comb begin
        nxt_mode  = mode_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_rdata = 8'h00;
        if (cpu_wr_i && cpu_addr_i == `ADDR_DISPLAY_MODE) begin
            nxt_mode = cpu_wdata_i;
        end
        if (cpu_bit_wr_i && cpu_addr_i == `ADDR_DISPLAY_MODE) begin
            nxt_mode[cpu_bit_sel_i] = cpu_bit_val_i;
        end
        if (cpu_wr_i && cpu_addr_i == `ADDR_DISPLAY_CONTROL) begin
            nxt_ctrl = cpu_wdata_i;
        end
        if (cpu_bit_wr_i && cpu_addr_i == `ADDR_DISPLAY_CONTROL) begin
            nxt_ctrl[cpu_bit_sel_i] = cpu_bit_val_i;
        end
        // Unused bits are not stored, guarding against software ignoring
        nxt_mode[`MODE_ZERO_POS] = 1'b0;
        nxt_ctrl = nxt_ctrl & `CTRL_STORED_MASK;
        if (rst_i) begin
            nxt_mode = `DISPLAY_MODE_RESET;
            nxt_ctrl = `DISPLAY_CONTROL_RESET;
        end
        if (cpu_rd_i) begin
            if (cpu_addr_i == `ADDR_DISPLAY_MODE) begin
                nxt_rdata = mode_ff;
            end else if (cpu_addr_i == `ADDR_DISPLAY_CONTROL) begin
                nxt_rdata = ctrl_ff;
            end else if (dmem_hit) begin
                nxt_rdata = {4'h0, dmem_ff[dmem_idx]};
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        mode_ff  <= nxt_mode;
        ctrl_ff  <= nxt_ctrl;
        rdata_ff <= nxt_rdata;
    end

    // Display memory: only the low nibble exists, the high nibble reads zero
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_SEG; i++) begin
                dmem_ff[i] <= `DMEM_RESET;
            end
        end else if (dmem_hit && cpu_wr_i) begin
            dmem_ff[dmem_idx] <= cpu_wdata_i[3:0];
        end else if (dmem_hit && cpu_bit_wr_i && !cpu_bit_sel_i[2]) begin
            dmem_ff[dmem_idx][cpu_bit_sel_i[1:0]] <= cpu_bit_val_i;
        end
    end

    // Mode decode; prohibited codes fall back to static, the least stressful drive
    always_comb begin
        case (mode_ff[`DISP_MODE_HI:`DISP_MODE_LO])
            `DMODE_DIV4_B3: duty = DUTY_DIV4_B3;
            `DMODE_DIV3_B3: duty = DUTY_DIV3_B3;
            `DMODE_DIV3_B2: duty = DUTY_DIV3_B2;
            `DMODE_DIV2_B2: duty = DUTY_DIV2_B2;
            default:        duty = DUTY_STATIC;
        endcase
        case (duty)
            DUTY_DIV4_B3: nslots = 3'h4;
            DUTY_DIV3_B3: nslots = 3'h3;
            DUTY_DIV3_B2: nslots = 3'h3;
            DUTY_DIV2_B2: nslots = 3'h2;
            default:      nslots = 3'h1;
        endcase
        bias3       = (duty == DUTY_DIV4_B3) || (duty == DUTY_DIV3_B3);
        static_mode = (duty == DUTY_STATIC);
    end

    // Prohibited clock codes (bit 2 set) behave as code 0
    always_comb begin
        if (mode_ff[`CLK_SEL_HI]) begin
            div_mask = `DIV_MAX_MASK;
        end else begin
            div_mask = `DIV_MAX_MASK >> mode_ff[`CLK_SEL_LO+1:`CLK_SEL_LO];
        end
    end

    assign tick      = (div_ff & div_mask) == div_mask;
    assign last_slot = ({1'b0, slot_ff} + 3'h1) >= nslots;

    // Scan group: divider, common slot and frame polarity run on their own
    always_comb begin
        nxt_div   = div_ff + 17'h00001;
        nxt_slot  = slot_ff;
        nxt_pol   = pol_ff;
        nxt_power = ctrl_ff[`DRIVE_POWER_POS];
        if (tick) begin
            nxt_div  = 17'h00000;
            nxt_slot = last_slot ? 2'h0 : slot_ff + 2'h1;
            nxt_pol  = last_slot ? !pol_ff : pol_ff;
        end
        if (rst_i) begin
            nxt_div   = 17'h00000;
            nxt_slot  = 2'h0;
            nxt_pol   = 1'b0;
            nxt_power = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        div_ff   <= nxt_div;
        slot_ff  <= nxt_slot;
        pol_ff   <= nxt_pol;
        power_ff <= nxt_power;
    end

    assign cpu_rdata_o        = rdata_ff;
    assign drive_power_o      = power_ff;
    assign panel_scan_clock_o = pol_ff;

    // Common outputs; unused commons are released (open), except in static mode, where all commons are driven
    logic [NUM_COM-1:0][1:0] com_lvl_ff, nxt_com_lvl;
    logic [NUM_COM-1:0]      com_drv_ff, nxt_com_drv;

    always_comb begin
        for (int c = 0; c < NUM_COM; c++) begin
            nxt_com_drv[c] = static_mode || (c < int'(nslots));
            if (static_mode || (c == int'(slot_ff))) begin
                nxt_com_lvl[c] = pol_ff ? `LVL_VSS1 : `LVL_VLC0;
            end else if (bias3) begin
                nxt_com_lvl[c] = pol_ff ? `LVL_VLC1 : `LVL_VLC2;
            end else begin
                nxt_com_lvl[c] = `LVL_VLC1;
            end
            if (rst_i) begin
                nxt_com_drv[c] = 1'b0;
                nxt_com_lvl[c] = `LVL_VSS1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        com_lvl_ff <= nxt_com_lvl;
        com_drv_ff <= nxt_com_drv;
    end

    assign com_level_o = com_lvl_ff;
    assign com_drive_o = com_drv_ff;

    // Segment outputs, one lane per segment
    level_t              seg_nonsel;
    level_t              seg_sel;
    logic [NUM_SEG-1:0]  seg_drv_ff;
    level_t              seg_lvl_ff [NUM_SEG];

    always_comb begin
        seg_sel = pol_ff ? `LVL_VLC0 : `LVL_VSS1;
        if (bias3) begin
            seg_nonsel = pol_ff ? `LVL_VLC2 : `LVL_VLC1;
        end else begin
            seg_nonsel = pol_ff ? `LVL_VSS1 : `LVL_VLC0;
        end
    end

    for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
        logic   handed;
        logic   nxt_drv;
        level_t nxt_lvl;
        // Chosen at elaboration so no lane ever indexes past its select vector
        if (s < `SEG_BYTEWISE) begin : g_byte
            assign handed = port_byte_sel_i[s/(`SEG_BYTEWISE/`SEG_BYTE_GROUPS)];
        end else begin : g_bit
            assign handed = port_bit_sel_i[s-`SEG_BYTEWISE];
        end
        always_comb begin
            nxt_drv = !handed;
            if (!nxt_drv) begin
                nxt_lvl = `LVL_VSS1;
            end else if (disp_en && dmem_ff[s][slot_ff]) begin
                nxt_lvl = seg_sel;
            end else begin
                nxt_lvl = seg_nonsel;
            end
            if (rst_i) begin
                nxt_drv = 1'b0;
                nxt_lvl = `LVL_VSS1;
            end
        end
        always_ff @(posedge core_clk_i) begin
            seg_drv_ff[s] <= nxt_drv;
            seg_lvl_ff[s] <= nxt_lvl;
        end
        assign seg_level_o[s] = seg_lvl_ff[s];
    end

    assign seg_drive_o = seg_drv_ff;

    // Checks
    logic [16:0] gap_ff;
    always_ff @(posedge core_clk_i) begin
        if (rst_i || tick) begin
            gap_ff <= 17'h00000;
        end else begin
            gap_ff <= gap_ff + 17'h00001;
        end
    end

    sequence s_mode_byte_write;
        cpu_wr_i && cpu_addr_i == `ADDR_DISPLAY_MODE && !cpu_bit_wr_i;
    endsequence

    sequence s_steady_tick;
        tick && $stable(mode_ff) && !$past(rst_i);
    endsequence

    a_mode_reset: assert property (@(posedge core_clk_i) $fell(rst_i) |-> mode_ff == 8'h00)
        else $error("mode register not clear after reset");
    a_ctrl_reset: assert property (@(posedge core_clk_i) $fell(rst_i) |-> !drive_power_o)
        else $error("drive power on after reset");
    a_power_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
        cpu_wr_i && cpu_addr_i == `ADDR_DISPLAY_CONTROL && !cpu_bit_wr_i
        |-> ##2 drive_power_o == $past(cpu_wdata_i[0], 2))
        else $error("drive power does not follow control bit 0");
    a_mode_bit3_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_mode_byte_write |=> mode_ff[`MODE_ZERO_POS] == 1'b0
            && mode_ff[`DISPLAY_ENABLE_POS] == $past(cpu_wdata_i[`DISPLAY_ENABLE_POS]))
        else $error("mode byte write stored wrongly");
    a_tick_period: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_steady_tick ##1 (!tick && $stable(mode_ff))[*1] |=> gap_ff == 17'h00001)
        else $error("scan divider period wrong");
    a_tick_gap: assert property (@(posedge core_clk_i) disable iff (rst_i)
        tick && $stable(mode_ff) && gap_ff != 17'h00000 |-> gap_ff == div_mask)
        else $error("scan tick spacing does not match clock select");
    a_slot_range: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_steady_tick |=> {1'b0, slot_ff} < nslots)
        else $error("common slot outside time division");
    a_disp_off_nonsel: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !disp_en && seg_drv_ff[0] ##1 seg_drv_ff[0] |-> seg_lvl_ff[0] == $past(seg_nonsel))
        else $error("segment selected while display off");
    a_dmem_top: assert property (@(posedge core_clk_i) disable iff (rst_i)
        cpu_wr_i && cpu_addr_i == `ADDR_DMEM_LAST |=> dmem_ff[0] == $past(cpu_wdata_i[3:0]))
        else $error("segment 0 data not at top address");
    a_port_handover: assert property (@(posedge core_clk_i) disable iff (rst_i)
        port_bit_sel_i[0] && port_byte_sel_i[0] |=> !seg_drive_o[`SEG_BYTEWISE] && !seg_drive_o[0])
        else $error("segment still driven after handover");
    a_pol_frame: assert property (@(posedge core_clk_i) disable iff (rst_i)
        tick && last_slot |=> pol_ff != $past(pol_ff))
        else $error("polarity did not invert at frame end");

endmodule

// File: lcd_segment_driver_consts.svh
// Constants for the segment LCD controller/driver: addresses, fields, resets, codes.
// Assumes a byte-wide processor data port with 16-bit addresses.
`ifndef LCD_SEGMENT_DRIVER_CONSTS_SVH
`define LCD_SEGMENT_DRIVER_CONSTS_SVH

`define ADDR_DISPLAY_MODE    16'hFF90
`define ADDR_DISPLAY_CONTROL 16'hFF92
`define ADDR_DMEM_FIRST      16'hFA58
`define ADDR_DMEM_LAST       16'hFA7F

`define DISPLAY_MODE_RESET    8'h00
`define DISPLAY_CONTROL_RESET 8'h00
`define DMEM_RESET            4'h0

// Display mode register fields
`define DISPLAY_ENABLE_POS 7
`define MODE_ZERO_POS      3
`define CLK_SEL_HI         6
`define CLK_SEL_LO         4
`define DISP_MODE_HI       2
`define DISP_MODE_LO       0
// Display control register fields
`define CTRL_TOP_POS       7
`define DRIVE_POWER_POS    0
`define CTRL_STORED_MASK   8'h81

// Display mode codes
`define DMODE_DIV4_B3 3'h0
`define DMODE_DIV3_B3 3'h1
`define DMODE_DIV3_B2 3'h2
`define DMODE_DIV2_B2 3'h3
`define DMODE_STATIC  3'h4

// Divider: largest exponent is 17, code n subtracts n
`define DIV_MAX_MASK 17'h1FFFF

// Drive level codes (rail index)
`define LVL_VSS1 2'h0
`define LVL_VLC2 2'h1
`define LVL_VLC1 2'h2
`define LVL_VLC0 2'h3

`define SEG_BYTE_GROUPS 3
`define SEG_BYTEWISE    24

`endif

// File: lcd_segment_driver_pkg.sv
// Types shared by the segment LCD controller/driver.
// Assumes lcd_segment_driver_consts.svh supplies the numeric constants.
package lcd_segment_driver_pkg;
    typedef logic [1:0] level_t;
    typedef enum logic [2:0] {
        DUTY_DIV4_B3,
        DUTY_DIV3_B3,
        DUTY_DIV3_B2,
        DUTY_DIV2_B2,
        DUTY_STATIC
    } duty_e;
endpackage

// File: lcd_panel_model.sv
// Behavioural LCD panel: reports which pixels on common 0 see the full drive voltage.
// Assumes the driver's rail codes, 0 = VSS1 up to 3 = VLC0.
module lcd_panel_model
    import lcd_segment_driver_pkg::*;
#(
    parameter int NUM_SEG = 40
) (
    input  wire logic [3:0][1:0]         com_level_i,
    input  wire logic [3:0]              com_drive_i,
    input  wire logic [NUM_SEG-1:0][1:0] seg_level_i,
    input  wire logic [NUM_SEG-1:0]      seg_drive_i,
    output logic      [NUM_SEG-1:0]      lit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only opposite end rails light a pixel; half-bias rails must stay dark
    always_comb begin
        for (int s = 0; s < NUM_SEG; s++) begin
            lit_o[s] = com_drive_i[0] & seg_drive_i[s]
                     & (com_level_i[0][1] == com_level_i[0][0])
                     & (com_level_i[0] == ~seg_level_i[s]);
        end
    end
endmodule

// File: test_lcd_segment_driver.sv
// Self-checking bench for the segment LCD driver with a panel model on its outputs.
// Assumes the consts header and package are compiled first.
`include "lcd_segment_driver_consts.svh"

module test_lcd_segment_driver;
    timeunit 1ns;
    timeprecision 1ps;
    import lcd_segment_driver_pkg::*;
    logic                core_clk_i;
    logic                rst_i;
    logic [15:0]         cpu_addr_i;
    logic                cpu_wr_i;
    logic [7:0]          cpu_wdata_i;
    logic                cpu_bit_wr_i;
    logic [2:0]          cpu_bit_sel_i;
    logic                cpu_bit_val_i;
    logic                cpu_rd_i;
    logic [7:0]          cpu_rdata_o;
    logic [2:0]          port_byte_sel_i;
    logic [15:0]         port_bit_sel_i;
    logic [39:0][1:0]    seg_level_o;
    logic [39:0]         seg_drive_o;
    logic [3:0][1:0]     com_level_o;
    logic [3:0]          com_drive_o;
    logic                drive_power_o;
    logic                panel_scan_clock_o;
    logic [39:0]         lit;
    logic                rd_seen;
    logic [7:0]          exp_q[$];
    int                  bad_count;
    int                  tests_run;
    logic [31:0]         r;
    logic                p;
    int                  n;
    logic [3:0]          tbl [5] = '{4'hF, 4'h7, 4'h7, 4'h3, 4'hF};

    lcd_segment_driver dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .cpu_addr_i(cpu_addr_i),
        .cpu_wr_i(cpu_wr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_bit_wr_i(cpu_bit_wr_i),
        .cpu_bit_sel_i(cpu_bit_sel_i), .cpu_bit_val_i(cpu_bit_val_i), .cpu_rd_i(cpu_rd_i),
        .cpu_rdata_o(cpu_rdata_o), .port_byte_sel_i(port_byte_sel_i),
        .port_bit_sel_i(port_bit_sel_i), .seg_level_o(seg_level_o), .seg_drive_o(seg_drive_o),
        .com_level_o(com_level_o), .com_drive_o(com_drive_o), .drive_power_o(drive_power_o),
        .panel_scan_clock_o(panel_scan_clock_o));
    lcd_panel_model panel (.com_level_i(com_level_o), .com_drive_i(com_drive_o),
        .seg_level_i(seg_level_o), .seg_drive_i(seg_drive_o), .lit_o(lit));

    always #4 core_clk_i = ~core_clk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cpu_addr_i = a;
        cpu_wdata_i = d;
        cpu_wr_i = 1'b1;
        @(negedge core_clk_i);
        cpu_wr_i = 1'b0;
        @(negedge core_clk_i);
    endtask

    task automatic bw(input logic [15:0] a, input logic [2:0] b, input logic v);
        cpu_addr_i = a;
        cpu_bit_sel_i = b;
        cpu_bit_val_i = v;
        cpu_bit_wr_i = 1'b1;
        @(negedge core_clk_i);
        cpu_bit_wr_i = 1'b0;
        @(negedge core_clk_i);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cpu_addr_i = a;
        cpu_rd_i = 1'b1;
        @(negedge core_clk_i);
        cpu_rd_i = 1'b0;
        @(negedge core_clk_i);
    endtask

    task automatic idle(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask

    // Counts cycles to the next frame toggle; a stuck scan clock ends the run
    task automatic wait_tog(output int c);
        logic q;
        q = panel_scan_clock_o;
        c = 0;
        while (panel_scan_clock_o === q && c < 20000) begin
            @(negedge core_clk_i);
            c++;
        end
        if (c >= 20000) begin
            chk("scan_timeout", 40'h1, 40'h0);
            end_of_test();
        end
    endtask

    // Read data stands one cycle only, so it is sampled at the following falling edge
    always @(posedge core_clk_i) rd_seen <= cpu_rd_i & ~rst_i;
    always @(negedge core_clk_i) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) chk("read_queue", 40'h1, 40'h0);
            else chk("read_data", {32'h0, cpu_rdata_o}, {32'h0, exp_q.pop_front()});
        end
    end

    initial begin
        core_clk_i = 1'b0;
        rst_i = 1'b1;
        {cpu_addr_i, cpu_wr_i, cpu_wdata_i, cpu_bit_wr_i, cpu_bit_sel_i} = '0;
        {cpu_bit_val_i, cpu_rd_i, port_byte_sel_i, port_bit_sel_i} = '0;
        bad_count = 0;
        tests_run = 0;
        r = 32'hEBFE;
        idle(6);
        rst_i = 1'b0;
        chk("drive_power", drive_power_o, 40'h0);
        rd(`ADDR_DISPLAY_MODE, `DISPLAY_MODE_RESET);
        rd(`ADDR_DISPLAY_CONTROL, `DISPLAY_CONTROL_RESET);
        wr(`ADDR_DISPLAY_CONTROL, 8'h81);
        idle(1);
        chk("drive_power", drive_power_o, 40'h1);
        rd(`ADDR_DISPLAY_CONTROL, 8'h81);
        bw(`ADDR_DISPLAY_CONTROL, 3'h0, 1'b0);
        idle(1);
        chk("drive_power", drive_power_o, 40'h0);
        bw(`ADDR_DISPLAY_CONTROL, 3'h0, 1'b1);
        rd(`ADDR_DISPLAY_CONTROL, 8'h81);
        // Upper nibble has no storage, so a bit write there must not stick
        wr(`ADDR_DMEM_LAST, 8'hF5);
        bw(`ADDR_DMEM_LAST, 3'h5, 1'b1);
        rd(`ADDR_DMEM_LAST, 8'h05);
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            wr(`ADDR_DMEM_FIRST + 16'(r[15:0] % 40), r[23:16]);
            rd(`ADDR_DMEM_FIRST + 16'(r[15:0] % 40), {4'h0, r[19:16]});
        end
        rd(16'hFA57, 8'h00);
        rd(16'hFF91, 8'h00);
        for (int m = 0; m < 5; m++) begin
            wr(`ADDR_DISPLAY_MODE, {1'b1, 3'h3, 1'b0, m[2:0]});
            idle(2);
            chk("com_drive", com_drive_o, 40'(tbl[m]));
        end
        rd(`ADDR_DISPLAY_MODE, 8'hB4);
        r = lfsr(r);
        port_byte_sel_i = r[2:0];
        port_bit_sel_i = r[31:16];
        idle(2);
        chk("seg_drive", seg_drive_o, {~r[31:16], {8{~r[2]}}, {8{~r[1]}}, {8{~r[0]}}});
        port_byte_sel_i = 3'h7;
        port_bit_sel_i = 16'hFFFF;
        idle(2);
        chk("seg_all_port", seg_drive_o, 40'h0);
        port_byte_sel_i = 3'h0;
        port_bit_sel_i = 16'h0;
        wr(`ADDR_DMEM_LAST, 8'h01);
        wr(`ADDR_DMEM_LAST - 16'h1, 8'h00);
        wait_tog(n);
        wait_tog(n);
        chk("frame_cycles", 40'(n), 40'd16384);
        for (int k = 0; k < 2; k++) begin
            if (k > 0) wait_tog(n);
            idle(1);
            p = panel_scan_clock_o;
            chk("common_out_0_level", com_level_o[0], p ? `LVL_VSS1 : `LVL_VLC0);
            chk("common_out_3_level", com_level_o[3], com_level_o[0]);
            chk("seg0_level", seg_level_o[0], p ? `LVL_VLC0 : `LVL_VSS1);
            chk("seg1_level", seg_level_o[1], p ? `LVL_VSS1 : `LVL_VLC0);
            chk("pixel_lit", lit[1:0], 40'h1);
        end
        wr(`ADDR_DISPLAY_MODE, 8'h34);
        idle(2);
        chk("seg0_off", seg_level_o[0], p ? `LVL_VSS1 : `LVL_VLC0);
        chk("pixel_off", lit[0], 40'h0);
        idle(3);
        end_of_test();
    end
endmodule
